// ==== rtl/rtca_map.svh ====
// Register offsets, field positions and reset values of the alarm block
`ifndef RTCA_MAP_SVH
`define RTCA_MAP_SVH

// Byte offsets on the APB
`define RTCA_OFF_SEC_ALARM   8'h00
`define RTCA_OFF_MIN_ALARM   8'h04
`define RTCA_OFF_HOUR_ALARM  8'h08
`define RTCA_OFF_WDAY_ALARM  8'h0c
`define RTCA_OFF_DATE_ALARM  8'h10
`define RTCA_OFF_MON_ALARM   8'h14
`define RTCA_OFF_CTRL        8'h18

// Alarm register fields
`define RTCA_ENB_BIT         7
`define RTCA_SEC_MASK        8'h7f
`define RTCA_MIN_MASK        8'h7f
`define RTCA_HOUR_MASK       8'h3f
`define RTCA_WDAY_MASK       8'h07
`define RTCA_DATE_MASK       8'h3f
`define RTCA_MON_MASK        8'h1f
`define RTCA_ENB_RESET       1'b0

// Control register fields
`define RTCA_CF_BIT          7
`define RTCA_CIE_BIT         4
`define RTCA_AIE_BIT         3
`define RTCA_AF_BIT          0
`define RTCA_CTRL_RESET      8'h00

`endif

// ==== rtl/rtca_pkg.sv ====
// Types shared by the alarm block
package rtca_pkg;

  // Calendar counter values from the time base
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] mon;
  } rtca_cal_t;

  // Register selected by an APB address
  typedef enum {
    RTCA_SEL_SEC,
    RTCA_SEL_MIN,
    RTCA_SEL_HOUR,
    RTCA_SEL_WDAY,
    RTCA_SEL_DATE,
    RTCA_SEL_MON,
    RTCA_SEL_CTRL,
    RTCA_SEL_NONE
  } rtca_sel_t;

endpackage

// ==== rtl/rtca_field_cmp.sv ====
// One alarm register with its enable bit and its counter comparator
`timescale 1ns/1ps
`include "rtca_map.svh"

module rtca_field_cmp #(
  parameter logic [7:0] MASK = 8'h7f
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Register access
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // Compare
  input  wire logic [7:0] count,
  output logic            enabled,
  output logic            match
);

  logic       enb_reg;
  logic [7:0] value_reg;

  // Enable cleared by power-on reset or by a write with bit 7 zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      enb_reg <= `RTCA_ENB_RESET;
    end else if (wr_en) begin
      enb_reg <= wdata[`RTCA_ENB_BIT];
    end
  end

  // Alarm value is never initialised
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      value_reg <= wdata & MASK;
    end
  end

  assign rdata   = {enb_reg, value_reg[6:0] & MASK[6:0]};
  assign enabled = enb_reg;
  // Disabled fields always agree
  assign match   = !enb_reg || ((value_reg & MASK) == (count & MASK));

endmodule

// ==== rtl/rtca_flag.sv ====
// Sticky flag where a hardware set beats a clear
`timescale 1ns/1ps

module rtca_flag (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Control
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule

// ==== rtl/rtca_alarm_flags.sv ====
// Alarm compare, carry and alarm flags of the real-time clock, on APB
//
// Functional notes
// - Compare only fields whose bit 7 enable is set; alarm when all agree and at least one field is enabled.
// - Second alarm: BCD seconds 00-59 in bits 6:0.
// - Minute alarm: BCD minutes 00-59 in bits 6:0.
// - Hour alarm: BCD 00-23 in bits 5:0; bit 6 reads zero.
// - Weekday alarm: code 0-6 in bits 2:0; bits 6:3 read zero.
// - Date alarm: BCD 01-31 in bits 5:0; bit 6 reads zero.
// - Month alarm: BCD 01-12 in bits 4:0; bits 6:5 read zero.
// - Power-on reset clears enables; alarm values survive other resets.
// - Control clears on power-on; manual reset keeps carry flag only.
// - Control: carry flag 7, carry irq enable 4, alarm irq 3, alarm 0.
// - Control bits 6, 5, 2, 1 read zero; software writes zero.
// - Carry flag sets when a counter read meets a carry.
// - Writing 0 clears the carry flag; writing 1 sets it.
// - Carry interrupt is carry flag and its enable.
// - Alarm interrupt is alarm flag and its enable.
// - Alarm flag sets when a counter update enters full match and stays until cleared.
// - Writing 0 clears the alarm flag; writing 1 leaves it.
`timescale 1ns/1ps
`include "rtca_map.svh"

module rtca_alarm_flags (
  // Clock and resets
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              manual_reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Calendar time base
  input  wire rtca_pkg::rtca_cal_t cal,
  input  wire logic              cal_update,
  input  wire logic              sec_carry,
  input  wire logic              sub_carry,
  input  wire logic              cal_read,
  // Status and interrupts
  output logic                   alarm_match,
  output logic                   carry_irq,
  output logic                   alarm_irq
);

  localparam logic [7:0] FIELD_MASK [6] = '{
    `RTCA_SEC_MASK, `RTCA_MIN_MASK, `RTCA_HOUR_MASK,
    `RTCA_WDAY_MASK, `RTCA_DATE_MASK, `RTCA_MON_MASK
  };

  // Control reset image, split into its enable bits
  localparam logic [7:0] CTRL_RST = `RTCA_CTRL_RESET;

  rtca_pkg::rtca_sel_t sel;
  logic        apb_setup;
  logic        apb_access;
  logic        apb_wr;
  logic        wr_ctrl;
  logic [5:0]  wr_field;
  logic [7:0]  cal_arr [6];
  logic [7:0]  field_rd [6];
  logic [5:0]  field_en;
  logic [5:0]  field_match;
  logic        all_match;
  logic        match_prev_reg;
  logic        af_set;
  logic        cf_hw_set;
  logic        cf_set;
  logic        cf_clr;
  logic        af_clr;
  logic        carry_flag;
  logic        alarm_flag;
  logic        carry_irq_enable_reg;
  logic        alarm_irq_enable_reg;
  logic [7:0]  ctrl_rd;
  logic [7:0]  rd_next;
  logic [31:0] prdata_reg;

  // Address decode
  always_comb begin
    sel = rtca_pkg::RTCA_SEL_NONE;
    case (paddr)
      `RTCA_OFF_SEC_ALARM:  sel = rtca_pkg::RTCA_SEL_SEC;
      `RTCA_OFF_MIN_ALARM:  sel = rtca_pkg::RTCA_SEL_MIN;
      `RTCA_OFF_HOUR_ALARM: sel = rtca_pkg::RTCA_SEL_HOUR;
      `RTCA_OFF_WDAY_ALARM: sel = rtca_pkg::RTCA_SEL_WDAY;
      `RTCA_OFF_DATE_ALARM: sel = rtca_pkg::RTCA_SEL_DATE;
      `RTCA_OFF_MON_ALARM:  sel = rtca_pkg::RTCA_SEL_MON;
      `RTCA_OFF_CTRL:       sel = rtca_pkg::RTCA_SEL_CTRL;
      default:              sel = rtca_pkg::RTCA_SEL_NONE;
    endcase
  end

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  // Zero wait states; unmapped addresses answer with an error
  assign pready     = 1'b1;
  assign pslverr    = apb_access && (sel == rtca_pkg::RTCA_SEL_NONE);
  assign apb_wr     = apb_access && pwrite && pstrb[0]
                      && (sel != rtca_pkg::RTCA_SEL_NONE);
  assign wr_ctrl    = apb_wr && (sel == rtca_pkg::RTCA_SEL_CTRL);

  assign wr_field[0] = apb_wr && (sel == rtca_pkg::RTCA_SEL_SEC);
  assign wr_field[1] = apb_wr && (sel == rtca_pkg::RTCA_SEL_MIN);
  assign wr_field[2] = apb_wr && (sel == rtca_pkg::RTCA_SEL_HOUR);
  assign wr_field[3] = apb_wr && (sel == rtca_pkg::RTCA_SEL_WDAY);
  assign wr_field[4] = apb_wr && (sel == rtca_pkg::RTCA_SEL_DATE);
  assign wr_field[5] = apb_wr && (sel == rtca_pkg::RTCA_SEL_MON);

  assign cal_arr[0] = cal.sec;
  assign cal_arr[1] = cal.min;
  assign cal_arr[2] = cal.hour;
  assign cal_arr[3] = cal.wday;
  assign cal_arr[4] = cal.date;
  assign cal_arr[5] = cal.mon;

  // Six alarm fields, each masked to its BCD width
  for (genvar i = 0; i < 6; i++) begin : g_field
    rtca_field_cmp #(
      .MASK (FIELD_MASK[i])
    ) u_field (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wr_en   (wr_field[i]),
      .wdata   (pwdata[7:0]),
      .rdata   (field_rd[i]),
      .count   (cal_arr[i]),
      .enabled (field_en[i]),
      .match   (field_match[i])
    );
  end

  // Full match needs at least one enabled field
  assign all_match   = (&field_match) && (|field_en);
  assign alarm_match = all_match;

  // Match state seen at the last counter update
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      match_prev_reg <= 1'b0;
    end else if (cal_update) begin
      match_prev_reg <= all_match;
    end
  end

  // Alarm flag set on entry into match only
  assign af_set = cal_update && all_match && !match_prev_reg;
  assign af_clr = (wr_ctrl && !pwdata[`RTCA_AF_BIT])
                  || manual_reset;

  rtca_flag u_alarm_flag (
    .clk_sys (clk_sys),
    .reset   (reset),
    .set     (af_set),
    .clr     (af_clr),
    .q       (alarm_flag)
  );

  // Carry flag: read during a carry, or software write of 1
  assign cf_hw_set = cal_read && (sec_carry || sub_carry);
  assign cf_set    = cf_hw_set
                     || (wr_ctrl && pwdata[`RTCA_CF_BIT]);
  assign cf_clr    = wr_ctrl && !pwdata[`RTCA_CF_BIT];

  // Manual reset leaves the carry flag alone
  rtca_flag u_carry_flag (
    .clk_sys (clk_sys),
    .reset   (reset),
    .set     (cf_set),
    .clr     (cf_clr),
    .q       (carry_flag)
  );

  // Interrupt enables
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      carry_irq_enable_reg <= CTRL_RST[`RTCA_CIE_BIT];
      alarm_irq_enable_reg <= CTRL_RST[`RTCA_AIE_BIT];
    end else if (manual_reset) begin
      carry_irq_enable_reg <= 1'b0;
      alarm_irq_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      carry_irq_enable_reg <= pwdata[`RTCA_CIE_BIT];
      alarm_irq_enable_reg <= pwdata[`RTCA_AIE_BIT];
    end
  end

  assign carry_irq = carry_flag && carry_irq_enable_reg;
  assign alarm_irq = alarm_flag && alarm_irq_enable_reg;

  // Control readback; reserved bits stay zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`RTCA_CF_BIT]  = carry_flag;
    ctrl_rd[`RTCA_CIE_BIT] = carry_irq_enable_reg;
    ctrl_rd[`RTCA_AIE_BIT] = alarm_irq_enable_reg;
    ctrl_rd[`RTCA_AF_BIT]  = alarm_flag;
  end

  always_comb begin
    rd_next = 8'h00;
    case (sel)
      rtca_pkg::RTCA_SEL_SEC:  rd_next = field_rd[0];
      rtca_pkg::RTCA_SEL_MIN:  rd_next = field_rd[1];
      rtca_pkg::RTCA_SEL_HOUR: rd_next = field_rd[2];
      rtca_pkg::RTCA_SEL_WDAY: rd_next = field_rd[3];
      rtca_pkg::RTCA_SEL_DATE: rd_next = field_rd[4];
      rtca_pkg::RTCA_SEL_MON:  rd_next = field_rd[5];
      rtca_pkg::RTCA_SEL_CTRL: rd_next = ctrl_rd;
      default:                 rd_next = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_next};
    end
  end

  assign prdata = prdata_reg;

  // Agreement of each field seen through its readback
  logic [5:0] field_agree;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      field_agree[i] = !field_rd[i][`RTCA_ENB_BIT]
                       || (field_rd[i][6:0]
                           == (cal_arr[i][6:0] & FIELD_MASK[i][6:0]));
    end
  end

  // Checks
  sequence s_carry_read;
    cal_read && (sec_carry || sub_carry);
  endsequence

  sequence s_match_entry;
    cal_update && all_match && !match_prev_reg;
  endsequence

  sequence s_af_write0;
    wr_ctrl && !pwdata[`RTCA_AF_BIT];
  endsequence

  a_field_gate: assert property (
    @(posedge clk_sys) disable iff (reset)
    af_set |-> ((&field_agree) && (|field_en)))
    else $error("alarm set while an enabled field differs");

  a_hour_bits: assert property (
    @(posedge clk_sys) disable iff (reset)
    field_rd[2][6] == 1'b0 && field_rd[3][6:3] == 4'h0)
    else $error("hour or weekday reserved bits not zero");

  a_date_mon_bits: assert property (
    @(posedge clk_sys) disable iff (reset)
    field_rd[4][6] == 1'b0 && field_rd[5][6:5] == 2'h0)
    else $error("date or month reserved bits not zero");

  a_ctrl_manual: assert property (
    @(posedge clk_sys) disable iff (reset)
    manual_reset && !af_set |=>
      !alarm_flag && !carry_irq_enable_reg && !alarm_irq_enable_reg)
    else $error("manual reset left control bits set");

  a_ctrl_reserved: assert property (
    @(posedge clk_sys) disable iff (reset)
    apb_setup && !pwrite && sel == rtca_pkg::RTCA_SEL_CTRL |=>
      (prdata[6:5] == 2'h0 && prdata[2:1] == 2'h0))
    else $error("control reserved bits read nonzero");

  a_cf_capture: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_carry_read |=> carry_flag)
    else $error("carry flag missed a read during carry");

  a_cf_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_ctrl && !cf_hw_set |=> carry_flag == $past(pwdata[`RTCA_CF_BIT]))
    else $error("carry flag write not applied");

  a_carry_irq: assert property (
    @(posedge clk_sys) disable iff (reset)
    !carry_irq_enable_reg ##1 !carry_irq_enable_reg |-> !carry_irq)
    else $error("carry interrupt without enable");

  a_alarm_irq: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_match_entry ##1 alarm_irq_enable_reg |-> alarm_irq)
    else $error("alarm interrupt missing after match");

  a_af_sticky: assert property (
    @(posedge clk_sys) disable iff (reset)
    alarm_flag && !af_clr |=> alarm_flag)
    else $error("alarm flag dropped without a clear");

  a_af_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_af_write0 and !af_set |=> !alarm_flag)
    else $error("alarm flag not cleared by write of 0");

  a_af_keep: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_ctrl && pwdata[`RTCA_AF_BIT] && !af_set && !manual_reset
      |=> $stable(alarm_flag))
    else $error("write of 1 changed the alarm flag");

  a_no_enable: assert property (
    @(posedge clk_sys) disable iff (reset)
    field_en == 6'h00 |-> !af_set)
    else $error("alarm with no enabled field");

  a_af_once: assert property (
    @(posedge clk_sys) disable iff (reset)
    s_match_entry |=> !af_set
      ##1 (!af_set || ($past(cal_update) && !$past(all_match))))
    else $error("alarm set twice for one match");

  a_cf_sticky: assert property (
    @(posedge clk_sys) disable iff (reset)
    carry_flag && !cf_clr |=> carry_flag)
    else $error("carry flag dropped without a clear");

  a_alarm_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    !alarm_irq_enable_reg |-> !alarm_irq)
    else $error("alarm interrupt without enable");

  a_apb_ready: assert property (
    @(posedge clk_sys) disable iff (reset)
    apb_access |-> pready)
    else $error("access phase not answered");

endmodule

// ==== verif/testbench.sv ====
// Self-checking bench of the alarm compare and flag block over APB
`timescale 1ns/1ps
`include "rtca_map.svh"

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  n_mismatch++; $display("Error at %0t: got %h expected %h", \
  $time, a, b); end end

module testbench;
  logic                  clk_sys = 1'b0;
  logic                  reset;
  logic                  manual_reset;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  rtca_pkg::rtca_cal_t   cal;
  logic                  cal_update;
  logic                  sec_carry;
  logic                  sub_carry;
  logic                  cal_read;
  logic                  alarm_match;
  logic                  carry_irq;
  logic                  alarm_irq;
  logic [7:0]            rd_d;
  logic                  rd_err;
  logic [7:0]            masks [6];
  int                    n_mismatch = 0;
  int                    checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  rtca_alarm_flags i_rtca_alarm_flags (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .manual_reset (manual_reset),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .cal          (cal),
    .cal_update   (cal_update),
    .sec_carry    (sec_carry),
    .sub_carry    (sub_carry),
    .cal_read     (cal_read),
    .alarm_match  (alarm_match),
    .carry_irq    (carry_irq),
    .alarm_irq    (alarm_irq)
  );

  task automatic tick();
    @(posedge clk_sys);
  endtask

  // One APB transfer; setup, access until pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    tick();
    penable <= 1'b1;
    do tick(); while (pready !== 1'b1);
    rd_d    = prdata[7:0];
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    tick();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  // Counter update pulse with a new seconds value
  task automatic upd(input logic [7:0] s);
    cal.sec    <= s;
    cal_update <= 1'b1;
    tick();
    cal_update <= 1'b0;
    tick();
  endtask

  task automatic pulse(input logic r, input logic s, input logic u);
    cal_read  <= r;
    sec_carry <= s;
    sub_carry <= u;
    tick();
    cal_read  <= 1'b0;
    sec_carry <= 1'b0;
    sub_carry <= 1'b0;
    tick();
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (6000) tick();
    n_mismatch++;
    print_verdict();
  end

  initial begin
    masks = '{`RTCA_SEC_MASK, `RTCA_MIN_MASK, `RTCA_HOUR_MASK,
              `RTCA_WDAY_MASK, `RTCA_DATE_MASK, `RTCA_MON_MASK};
    reset = 1'b1;
    manual_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    cal = '0;
    cal_update = 1'b0;
    sec_carry = 1'b0;
    sub_carry = 1'b0;
    cal_read = 1'b0;
    repeat (5) tick();
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      `CHK(rd_d & 8'h80, 8'h00)
      wr(8'(i * 4), 8'hff);
      rd(8'(i * 4));
      `CHK(rd_d, 8'h80 | masks[i])
      wr(8'(i * 4), 8'h00);
    end
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, `RTCA_CTRL_RESET)
    // Flag write semantics; reserved bits written as zero
    wr(`RTCA_OFF_CTRL, 8'h99);
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, 8'h98)
    `CHK(carry_irq, 1'b1)
    `CHK(alarm_irq, 1'b0)
    wr(`RTCA_OFF_CTRL, 8'h10);
    `CHK(carry_irq, 1'b0)
    rd(8'h1c);
    `CHK({rd_err, rd_d}, 9'h100)
    // No field enabled: no alarm
    wr(`RTCA_OFF_CTRL, 8'h08);
    upd(8'h00);
    `CHK(alarm_match, 1'b0)
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, 8'h08)
    // Seconds and minutes enabled, hour disabled and unequal
    wr(`RTCA_OFF_SEC_ALARM, 8'hc5);
    wr(`RTCA_OFF_MIN_ALARM, 8'hb0);
    wr(`RTCA_OFF_HOUR_ALARM, 8'h23);
    cal.min <= 8'h30;
    upd(8'h44);
    `CHK(alarm_match, 1'b0)
    `CHK(alarm_irq, 1'b0)
    upd(8'h45);
    `CHK(alarm_match, 1'b1)
    `CHK(alarm_irq, 1'b1)
    wr(`RTCA_OFF_CTRL, 8'h09);
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, 8'h09)
    wr(`RTCA_OFF_CTRL, 8'h08);
    `CHK(alarm_irq, 1'b0)
    upd(8'h45);
    `CHK(alarm_irq, 1'b0)
    upd(8'h46);
    upd(8'h45);
    `CHK(alarm_irq, 1'b1)
    wr(`RTCA_OFF_CTRL, 8'h00);
    upd(8'h46);
    upd(8'h45);
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, 8'h01)
    `CHK(alarm_irq, 1'b0)
    // Hour and weekday join the match
    wr(`RTCA_OFF_HOUR_ALARM, 8'ha3);
    wr(`RTCA_OFF_WDAY_ALARM, 8'h86);
    upd(8'h45);
    `CHK(alarm_match, 1'b0)
    cal.hour <= 8'h23;
    cal.wday <= 8'h06;
    upd(8'h45);
    `CHK(alarm_match, 1'b1)
    // Carry events
    wr(`RTCA_OFF_CTRL, 8'h10);
    pulse(1'b1, 1'b0, 1'b0);
    `CHK(carry_irq, 1'b0)
    pulse(1'b0, 1'b1, 1'b1);
    `CHK(carry_irq, 1'b0)
    pulse(1'b1, 1'b1, 1'b0);
    `CHK(carry_irq, 1'b1)
    wr(`RTCA_OFF_CTRL, 8'h10);
    pulse(1'b1, 1'b0, 1'b1);
    `CHK(carry_irq, 1'b1)
    wr(`RTCA_OFF_CTRL, 8'h80);
    `CHK(carry_irq, 1'b0)
    // Manual reset keeps carry flag and alarm values
    wr(`RTCA_OFF_CTRL, 8'h98);
    manual_reset <= 1'b1;
    tick();
    manual_reset <= 1'b0;
    tick();
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, 8'h80)
    // Write with its byte strobe off is ignored
    pstrb <= 4'h0;
    wr(`RTCA_OFF_SEC_ALARM, 8'h80);
    pstrb <= 4'hf;
    rd(`RTCA_OFF_SEC_ALARM);
    `CHK(rd_d, 8'hc5)
    reset <= 1'b1;
    tick();
    reset <= 1'b0;
    rd(`RTCA_OFF_CTRL);
    `CHK(rd_d, 8'h00)
    rd(`RTCA_OFF_SEC_ALARM);
    `CHK(rd_d, 8'h45)
    print_verdict();
  end
endmodule
